// ==== exp_pkg.sv ====
// shared constants for the two-wire expander port and its host end
package exp_pkg;
   localparam logic [6:0] ADDR_SEL0   = 7'h20;
   localparam logic [6:0] ADDR_WIDE0  = 7'h3E;
   localparam logic [6:0] ADDR_WIDE1  = 7'h3F;
   localparam logic [6:0] ADDR_WIDE2  = 7'h70;
   localparam logic [6:0] ADDR_WIDE3  = 7'h71;
   localparam logic [7:0] SWRST_KEY1  = 8'h12;
   localparam logic [7:0] SWRST_KEY2  = 8'h34;
   localparam logic [7:0] REG_SWRST   = 8'h7D;
   localparam logic [7:0] REG_MISC    = 8'h1F;
   localparam int         MISC_AUTOINC_N = 0;
   localparam int         MISC_RST_LEDONLY = 2;
   localparam logic [7:0] MISC_RESET  = 8'h00;
   localparam int         NREGS       = 128;
   // reset timings in ns, counted on the link clock (32 ns)
   localparam int         LINK_NS     = 32;
   localparam int         RESET_PULSE_MIN_NS = 2500;
   localparam int         RESET_PULSE_CYC =
      (RESET_PULSE_MIN_NS + LINK_NS - 1) / LINK_NS;
   localparam int         POR_DURATION_NS = 2500;
   localparam int         POR_CYC = (POR_DURATION_NS + LINK_NS - 1) / LINK_NS;
   localparam int         HOST_DIV   = 2;
   localparam int         CORE_NS    = 25;
endpackage

// ==== exp_link_if.sv ====
// two-wire link between expander port and host master
`timescale 1ns/1ps
`default_nettype none
interface exp_link_if;
   logic link_clk;
   logic scl_o;
   logic scl_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic external_reset_n;
   logic scl;
   logic sda;
   // open drain: low wins when any enabled driver pulls low
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((sda_host_oe && !sda_host_o) ||
                  (sda_dev_oe && !sda_dev_o));
   modport dev (input link_clk, scl, sda, external_reset_n,
                output sda_dev_o, sda_dev_oe);
   modport host (input scl, sda,
                 output scl_o, scl_oe, sda_host_o, sda_host_oe,
                 external_reset_n);
endinterface
`default_nettype wire

// ==== exp_host.sv ====
// host master end: drives the clock line and runs one byte-level transfer
`timescale 1ns/1ps
`default_nettype none
module exp_host (
   // system
   input  wire logic       core_clk,
   input  wire logic       srst,
   // command
   input  wire logic       cmd_valid,
   input  wire logic       cmd_start,
   input  wire logic       cmd_stop,
   input  wire logic       cmd_read,
   input  wire logic       cmd_last,
   input  wire logic [7:0] cmd_data,
   input  wire logic       cmd_dev_reset,
   output logic            cmd_ready,
   output logic            rsp_valid,
   output logic [7:0]      rsp_data,
   output logic            rsp_ack,
   // link
   exp_link_if.host        link
);
   typedef enum {H_IDLE, H_START, H_BIT, H_ACK, H_STOP, H_DONE} hst_t;
   hst_t       st, next_st;
   logic [1:0] ph, next_ph;
   logic [3:0] bitn, next_bitn;
   logic [7:0] sh, next_sh;
   logic       rd, next_rd, lst, next_lst, stp, next_stp;
   logic       ack, next_ack;
   logic       scl_q, next_scl, sda_q, next_sda, rst_q, next_rst;
   logic       s1, s2;
   logic       tick;
   logic [7:0] div, next_div;
   assign tick = (div == 8'(exp_pkg::HOST_DIV - 1));
   always_ff @(posedge core_clk) begin
      s1 <= link.sda;
      s2 <= s1;
   end
   always_comb begin
      next_st = st; next_ph = ph; next_bitn = bitn; next_sh = sh;
      next_rd = rd; next_lst = lst; next_stp = stp; next_ack = ack;
      next_scl = scl_q; next_sda = sda_q; next_rst = !cmd_dev_reset;
      next_div = tick ? 8'h00 : div + 8'h01;
      case (st)
         H_IDLE: if (cmd_valid) begin
            next_sh = cmd_data; next_rd = cmd_read; next_lst = cmd_last;
            next_stp = cmd_stop; next_bitn = 4'h0; next_ph = 2'h0;
            next_st = cmd_start ? H_START : H_BIT;
         end
         H_START: if (tick) begin // start or repeated start
            next_ph = ph + 2'h1;
            case (ph)
               2'h0: begin next_sda = 1'b1; next_scl = 1'b0; end
               2'h1: next_scl = 1'b1;
               2'h2: next_sda = 1'b0;
               default: begin next_scl = 1'b0; next_st = H_BIT; end
            endcase
         end
         H_BIT: if (tick) begin // msb first, byte of 8
            next_ph = ph + 2'h1;
            case (ph)
               2'h0: next_sda = rd ? 1'b1 : sh[7];
               2'h1: next_scl = 1'b1;
               2'h2: next_sh = {sh[6:0], s2};
               default: begin
                  next_scl = 1'b0;
                  next_bitn = bitn + 4'h1;
                  if (bitn == 4'h7) next_st = H_ACK;
               end
            endcase
         end
         H_ACK: if (tick) begin // read ends with nack on last
            next_ph = ph + 2'h1;
            case (ph)
               2'h0: next_sda = rd ? lst : 1'b1;
               2'h1: next_scl = 1'b1;
               2'h2: next_ack = !s2;
               default: begin
                  next_scl = 1'b0;
                  next_st = stp ? H_STOP : H_DONE;
               end
            endcase
         end
         H_STOP: if (tick) begin
            next_ph = ph + 2'h1;
            case (ph)
               2'h0: next_sda = 1'b0;
               2'h1: next_scl = 1'b1;
               2'h2: next_sda = 1'b1;
               default: next_st = H_DONE;
            endcase
         end
         H_DONE: next_st = H_IDLE;
         default: next_st = H_IDLE;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (srst) begin
         st <= H_IDLE; ph <= 2'h0; bitn <= 4'h0; sh <= 8'h00;
         rd <= 1'b0; lst <= 1'b0; stp <= 1'b0; ack <= 1'b0;
         scl_q <= 1'b1; sda_q <= 1'b1; rst_q <= 1'b1; div <= 8'h00;
         cmd_ready <= 1'b0; rsp_valid <= 1'b0; rsp_data <= 8'h00;
         rsp_ack <= 1'b0;
      end else begin
         st <= next_st; ph <= next_ph; bitn <= next_bitn; sh <= next_sh;
         rd <= next_rd; lst <= next_lst; stp <= next_stp; ack <= next_ack;
         scl_q <= next_scl; sda_q <= next_sda; rst_q <= next_rst;
         div <= next_div;
         cmd_ready <= (next_st == H_IDLE);
         rsp_valid <= (st == H_DONE);
         rsp_data <= sh;
         rsp_ack <= ack;
      end
   end
   assign link.scl_o = scl_q;
   assign link.scl_oe = !scl_q;
   assign link.sda_host_o = sda_q;
   assign link.sda_host_oe = !sda_q;
   assign link.external_reset_n = rst_q;
endmodule
`default_nettype wire

// ==== exp_dev.sv ====
// expander slave port: two-wire register access and reset handling
`timescale 1ns/1ps
`default_nettype none
module exp_dev (
   // system side
   input  wire logic       core_clk,
   input  wire logic       srst,
   input  wire logic [1:0] addr_sel,
   input  wire logic       wide_variant,
   output logic [7:0]      misc_config_reg,
   output logic            led_counter_reset,
   output logic            ready,
   // link
   exp_link_if.dev         link
);
   typedef enum {D_IDLE, D_ADDR, D_AACK, D_WR, D_WACK, D_RD, D_RACK} dst_t;
   dst_t       st, next_st;
   logic       scl1, scl2, scl3, sda1, sda2, sda3;
   logic       rn1, rn2;
   logic [3:0] bitn, next_bitn;
   logic [7:0] sh, next_sh;
   logic [6:0] idx, next_idx;
   logic       have_idx, next_have_idx;
   logic       key1, next_key1;
   logic       rd, next_rd;
   logic       sda_q, next_sda;
   logic [7:0] regs [exp_pkg::NREGS];
   logic       wr_en;
   logic [6:0] wr_idx;
   logic [7:0] wr_dat;
   logic       soft_rst;
   logic [7:0] lowcnt;
   logic [7:0] porcnt;
   logic       por_done, pin_rst, full_rst, led_rst;
   logic [6:0] my_addr;
   logic       scl_rise, scl_fall, start_c, stop_c;
   logic       rdy1, rdy2, led1, led2;
   logic       rst1, rst2;
   logic       rdy_l, led_l;
   logic [1:0] asel1, asel2;
   logic       wide1, wide2;
   logic       swrst, next_swrst;
   // the device samples the link on its own clock; scl is data here
   // any scl phase longer than three link clocks is followed
   always_ff @(posedge link.link_clk) begin
      scl1 <= link.scl; scl2 <= scl1; scl3 <= scl2;
      sda1 <= link.sda; sda2 <= sda1; sda3 <= sda2;
      rn1 <= link.external_reset_n; rn2 <= rn1;
      rst1 <= srst;
      rst2 <= rst1;
      asel1 <= addr_sel;
      asel2 <= asel1;
      wide1 <= wide_variant;
      wide2 <= wide1;
   end
   assign scl_rise = scl2 && !scl3;
   assign scl_fall = !scl2 && scl3;
   assign start_c = scl2 && scl3 && !sda2 && sda3;
   assign stop_c = scl2 && scl3 && sda2 && !sda3;
   // fixed 7-bit address table per variant
   always_comb begin
      my_addr = exp_pkg::ADDR_SEL0 | {5'h00, asel2};
      if (wide2) begin
         case (asel2)
            2'h0: my_addr = exp_pkg::ADDR_WIDE0;
            2'h1: my_addr = exp_pkg::ADDR_WIDE1;
            2'h2: my_addr = exp_pkg::ADDR_WIDE2;
            default: my_addr = exp_pkg::ADDR_WIDE3;
         endcase
      end
   end
   // pin must stay low a minimum time before it counts
   always_ff @(posedge link.link_clk) begin
      if (rn2) lowcnt <= 8'h00;
      else if (lowcnt != 8'hFF) lowcnt <= lowcnt + 8'h01;
   end
   assign pin_rst = !rn2 && (lowcnt >= 8'(exp_pkg::RESET_PULSE_CYC - 1));
   assign led_rst = pin_rst && misc_config_reg[exp_pkg::MISC_RST_LEDONLY];
   // power-on procedure: counter starts after the pin first reads high
   // the core reset stands in for the supply coming up
   always_ff @(posedge link.link_clk) begin
      if (rst2) porcnt <= 8'h00;
      else if (!rn2 && !por_done) porcnt <= 8'h00;
      else if (!por_done) porcnt <= porcnt + 8'h01;
   end
   assign por_done = (porcnt >= 8'(exp_pkg::POR_CYC));
   // full reset holds the port until the pin rises again
   assign full_rst = !por_done || (pin_rst && !led_rst) || soft_rst;
   always_comb begin
      next_st = st; next_bitn = bitn; next_sh = sh; next_idx = idx;
      next_have_idx = have_idx; next_key1 = key1; next_rd = rd;
      next_sda = sda_q;
      next_swrst = swrst;
      wr_en = 1'b0; wr_idx = idx; wr_dat = sh;
      if (start_c) begin
         next_st = D_ADDR; next_bitn = 4'h0; next_sda = 1'b1;
         next_swrst = 1'b0;
      end else if (stop_c) begin
         next_st = D_IDLE; next_sda = 1'b1;
         next_swrst = 1'b0;
      end else begin
         case (st)
            D_IDLE: next_sda = 1'b1;
            D_ADDR: if (scl_rise) begin
               next_sh = {sh[6:0], sda2};
               next_bitn = bitn + 4'h1;
               if (bitn == 4'h7) next_st = D_AACK;
            end
            D_AACK: if (scl_fall) begin
               // general call and foreign addresses fall silent
               if (sh[7:1] == my_addr && bitn == 4'h8) begin
                  next_sda = 1'b0; next_rd = sh[0]; next_bitn = 4'h9;
                  next_have_idx = 1'b0;
               end else if (bitn == 4'h9) begin
                  next_sda = 1'b1; next_bitn = 4'h0;
                  next_st = rd ? D_RD : D_WR;
                  if (rd) next_sda = regs[idx][7];
                  next_sh = regs[idx];
               end else next_st = D_IDLE;
            end
            D_WR: if (scl_rise) begin
               next_sh = {sh[6:0], sda2};
               next_bitn = bitn + 4'h1;
               if (bitn == 4'h7) next_st = D_WACK;
            end
            D_WACK: if (scl_fall) begin
               if (bitn == 4'h8) begin
                  next_sda = 1'b0; next_bitn = 4'h9;
                  if (!have_idx) begin
                     next_idx = sh[6:0]; next_have_idx = 1'b1;
                  end else begin
                     wr_en = 1'b1;
                     if (!misc_config_reg[exp_pkg::MISC_AUTOINC_N])
                        next_idx = idx + 7'h01;
                     if ({1'b0, idx} == exp_pkg::REG_SWRST)
                        next_key1 = (sh == exp_pkg::SWRST_KEY1);
                     else next_key1 = 1'b0;
                     next_swrst = ({1'b0, idx} == exp_pkg::REG_SWRST) &&
                                  key1 && (sh == exp_pkg::SWRST_KEY2);
                  end
               end else begin
                  next_sda = 1'b1; next_bitn = 4'h0; next_st = D_WR;
               end
            end
            D_RD: if (scl_fall) begin
               next_bitn = bitn + 4'h1;
               next_sh = {sh[6:0], 1'b0};
               if (bitn == 4'h7) begin
                  next_sda = 1'b1; next_st = D_RACK;
               end else next_sda = sh[6];
            end
            D_RACK: if (scl_rise) begin
               if (sda2) next_st = D_IDLE; // nack ends the read
               else begin
                  if (!misc_config_reg[exp_pkg::MISC_AUTOINC_N])
                     next_idx = idx + 7'h01;
                  next_st = D_AACK; next_bitn = 4'h9; next_rd = 1'b1;
               end
            end
            default: next_st = D_IDLE;
         endcase
      end
   end
   // second key must be the very next write to the reset register; the
   // reset waits for the ack bit to end so the host still sees its ack
   assign soft_rst = swrst && scl_fall && (st == D_WACK);
   always_ff @(posedge link.link_clk) begin
      if (full_rst) begin
         st <= D_IDLE; bitn <= 4'h0; sh <= 8'h00; idx <= 7'h00;
         have_idx <= 1'b0; key1 <= 1'b0; rd <= 1'b0; sda_q <= 1'b1;
         swrst <= 1'b0;
      end else begin
         st <= next_st; bitn <= next_bitn; sh <= next_sh; idx <= next_idx;
         have_idx <= next_have_idx; key1 <= next_key1; rd <= next_rd;
         sda_q <= next_sda;
         swrst <= next_swrst;
      end
   end
   genvar g;
   generate
      for (g = 0; g < exp_pkg::NREGS; g++) begin : g_reg
         always_ff @(posedge link.link_clk) begin
            if (full_rst)
               regs[g] <= (g == int'(exp_pkg::REG_MISC)) ?
                          exp_pkg::MISC_RESET : 8'h00;
            else if (wr_en && wr_idx == 7'(g))
               regs[g] <= wr_dat;
         end
      end
   endgenerate
   assign misc_config_reg = regs[exp_pkg::REG_MISC[6:0]];
   assign link.sda_dev_o = sda_q;
   assign link.sda_dev_oe = !sda_q;
   // registered first so no combinational glitch crosses domains
   always_ff @(posedge link.link_clk) begin
      rdy_l <= por_done && !full_rst;
      led_l <= led_rst;
   end
   // status levels into the core domain
   always_ff @(posedge core_clk) begin
      rdy1 <= rdy_l;
      rdy2 <= rdy1;
      led1 <= led_l;
      led2 <= led1;
      if (srst) begin
         ready <= 1'b0;
         led_counter_reset <= 1'b0;
      end else begin
         ready <= rdy2;
         led_counter_reset <= led2;
      end
   end
endmodule
`default_nettype wire

// ==== exp_link_properties.sv ====
// concurrent checks on the two-wire link between host and expander port
`timescale 1ns/1ps
`default_nettype none
module exp_link_properties (
   // clock and reset pin
   input wire logic link_clk,
   input wire logic external_reset_n,
   // per-driver lines
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_host_o,
   input wire logic sda_host_oe,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe,
   // resolved lines
   input wire logic scl,
   input wire logic sda
);
   wire dev_pull = sda_dev_oe && !sda_dev_o;
   // lines are unknown until the port has seen its first reset
   bit [3:0] warm;
   always_ff @(posedge link_clk)
      if (warm != 4'hF) warm <= warm + 4'h1;
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!external_reset_n || warm != 4'hF);
   sequence s_start; scl && $past(scl) && $fell(sda); endsequence
   sequence s_stop; scl && $past(scl) && $rose(sda); endsequence
   property p_dev_hold; scl && $past(scl) |-> $stable(dev_pull); endproperty
   a_dev_hold: assert property (p_dev_hold)
      else $error("device moved sda while scl high");
   property p_free_at_start; s_start |-> !dev_pull; endproperty
   a_free_at_start: assert property (p_free_at_start)
      else $error("device pulls sda at start");
   property p_quiet_stop; s_stop |-> !dev_pull [*8]; endproperty
   a_quiet_stop: assert property (p_quiet_stop)
      else $error("device pulls sda after stop");
   // the pull shows one sample late, so look at scl where it began
   property p_pull_scl_low; $rose(dev_pull) |-> !$past(scl); endproperty
   a_pull_scl_low: assert property (p_pull_scl_low)
      else $error("device pull began with scl high");
   property p_pull_short; $rose(dev_pull) |-> ##[1:120] !dev_pull; endproperty
   a_pull_short: assert property (p_pull_short)
      else $error("device holds sda too long");
   property p_start_clock; s_start |-> ##[1:20] !scl; endproperty
   a_start_clock: assert property (p_start_clock)
      else $error("no clock after start");
   property p_por_quiet; $rose(external_reset_n) |-> !dev_pull [*8];
   endproperty
   a_por_quiet: assert property (p_por_quiet)
      else $error("device pulls sda during reset procedure");
   property p_idle_stop; s_stop |-> scl [*4]; endproperty
   a_idle_stop: assert property (p_idle_stop)
      else $error("clock line moved right after stop");
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench: host end and expander port joined over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic       core_clk, srst, wide_variant, led_counter_reset, ready;
   logic [1:0] addr_sel;
   logic [7:0] misc_config_reg, cmd_data, rsp_data;
   logic       cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_last;
   logic       cmd_dev_reset, cmd_ready, rsp_valid, rsp_ack;
   int         mismatches, comparisons;
   logic [6:0] tbl [8] = '{7'h20, 7'h21, 7'h22, 7'h23,
                           7'h3E, 7'h3F, 7'h70, 7'h71};
   localparam logic [7:0] FIX = 8'h01 << exp_pkg::MISC_AUTOINC_N;
   localparam logic [7:0] LED = 8'h01 << exp_pkg::MISC_RST_LEDONLY;
   localparam logic [7:0] MI = exp_pkg::REG_MISC;
   exp_link_if link ();
   exp_dev u_exp_dev (.core_clk(core_clk), .srst(srst),
      .addr_sel(addr_sel), .wide_variant(wide_variant),
      .misc_config_reg(misc_config_reg),
      .led_counter_reset(led_counter_reset), .ready(ready), .link(link));
   exp_host u_exp_host (.core_clk(core_clk), .srst(srst),
      .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
      .cmd_read(cmd_read), .cmd_last(cmd_last), .cmd_data(cmd_data),
      .cmd_dev_reset(cmd_dev_reset), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
      .link(link));
   exp_link_properties u_exp_link_properties (.link_clk(link.link_clk),
      .external_reset_n(link.external_reset_n), .scl_o(link.scl_o),
      .scl_oe(link.scl_oe), .sda_host_o(link.sda_host_o),
      .sda_host_oe(link.sda_host_oe), .sda_dev_o(link.sda_dev_o),
      .sda_dev_oe(link.sda_dev_oe), .scl(link.scl), .sda(link.sda));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // odd offset keeps the link clock out of step with the core clock
   initial begin
      link.link_clk = 1'b0;
      #7;
      forever #16 link.link_clk = ~link.link_clk;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic xfer(input logic st, sp, rd, lst, input logic [7:0] d,
                       output logic ack, output logic [7:0] q);
      int n;
      @(posedge core_clk);
      cmd_start <= st;
      cmd_stop <= sp;
      cmd_read <= rd;
      cmd_last <= lst;
      cmd_data <= d;
      cmd_valid <= 1'b1;
      n = 0;
      do begin @(negedge core_clk); n++; end
      while (cmd_ready !== 1'b1 && n < 4000);
      if (n >= 4000) mismatches++;
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      n = 0;
      do begin @(negedge core_clk); n++; end
      while (rsp_valid !== 1'b1 && n < 4000);
      if (n >= 4000) mismatches++;
      ack = rsp_ack;
      q = rsp_data;
   endtask
   task automatic probe(input logic [6:0] a, input logic exp);
      logic ack;
      logic [7:0] q;
      xfer(1'b1, 1'b1, 1'b0, 1'b0, {a, 1'b0}, ack, q);
      chk_bit(ack, exp);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] idx,
                     input logic [7:0] d [3], input int n);
      logic ack;
      logic [7:0] q;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {a, 1'b0}, ack, q);
      chk_bit(ack, 1'b1);
      xfer(1'b0, n == 0, 1'b0, 1'b0, idx, ack, q);
      chk_bit(ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         xfer(1'b0, i == n - 1, 1'b0, 1'b0, d[i], ack, q);
         chk_bit(ack, 1'b1);
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] idx,
                     input logic [7:0] e [3], input int n);
      logic ack;
      logic [7:0] q;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {a, 1'b0}, ack, q);
      xfer(1'b0, 1'b0, 1'b0, 1'b0, idx, ack, q);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, {a, 1'b1}, ack, q);
      chk_bit(ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         xfer(1'b0, i == n - 1, 1'b1, i == n - 1, 8'hFF, ack, q);
         chk8(q, e[i]);
      end
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      do begin @(negedge core_clk); n++; end
      while (ready !== 1'b1 && n < 2000);
      chk_bit(ready, 1'b1);
   endtask
   task automatic pin_reset(input logic led_only);
      @(posedge core_clk);
      cmd_dev_reset <= 1'b1;
      repeat (exp_pkg::RESET_PULSE_MIN_NS / exp_pkg::CORE_NS + 20)
         @(posedge core_clk);
      @(negedge core_clk);
      chk_bit(led_counter_reset, led_only);
      @(posedge core_clk);
      cmd_dev_reset <= 1'b0;
      wait_ready();
   endtask
   initial begin
      #1000000;
      mismatches++;
      $display("watchdog expired at %0t", $time);
      tally_and_finish();
   end
   initial begin
      {srst, cmd_valid, cmd_start, cmd_stop} = 4'hF;
      {cmd_read, cmd_last, cmd_dev_reset, wide_variant} = 4'h0;
      addr_sel = 2'b00;
      cmd_data = 8'h00;
      mismatches = 0;
      comparisons = 0;
      cmd_valid = 1'b0;
      repeat (6) @(posedge core_clk);
      srst <= 1'b0;
      wait_ready();
      for (int v = 0; v < 2; v++) begin
         for (int s = 0; s < 4; s++) begin
            @(posedge core_clk);
            wide_variant <= v[0];
            addr_sel <= s[1:0];
            probe(tbl[4 * v + s], 1'b1);
            probe(tbl[4 * v + (s ^ 1)], 1'b0);
            probe(7'h00, 1'b0);
            probe(7'h78, 1'b0);
         end
      end
      @(posedge core_clk);
      {wide_variant, addr_sel} <= 3'h0;
      $display("test addressing done");
      wr(7'h20, 8'h05, '{8'hA1, 8'hB2, 8'hC3}, 3);
      rd(7'h20, 8'h05, '{8'hA1, 8'hB2, 8'hC3}, 3);
      wr(7'h20, 8'h40, '{8'h5A, 8'h00, 8'h00}, 1);
      rd(7'h20, 8'h06, '{8'hB2, 8'h00, 8'h00}, 1);
      $display("test auto increment done");
      wr(7'h20, MI, '{FIX, 8'h00, 8'h00}, 1);
      chk8(misc_config_reg, FIX);
      wr(7'h20, 8'h10, '{8'h11, 8'h22, 8'h00}, 2);
      rd(7'h20, 8'h10, '{8'h22, 8'h22, 8'h22}, 3);
      rd(7'h20, 8'h11, '{8'h00, 8'h00, 8'h00}, 1);
      $display("test fixed index done");
      wr(7'h20, MI, '{LED, 8'h00, 8'h00}, 1);
      pin_reset(1'b1);
      chk8(misc_config_reg, LED);
      rd(7'h20, 8'h05, '{8'hA1, 8'h00, 8'h00}, 1);
      wr(7'h20, MI, '{FIX, 8'h00, 8'h00}, 1);
      pin_reset(1'b0);
      chk8(misc_config_reg, exp_pkg::MISC_RESET);
      rd(7'h20, 8'h05, '{8'h00, 8'h00, 8'h00}, 1);
      $display("test reset pin done");
      wr(7'h20, 8'h05, '{8'h77, 8'h00, 8'h00}, 1);
      wr(7'h20, MI, '{FIX, 8'h00, 8'h00}, 1);
      wr(7'h20, exp_pkg::REG_SWRST, '{exp_pkg::SWRST_KEY1, 8'h00, 8'h00}, 1);
      chk8(misc_config_reg, FIX);
      wr(7'h20, exp_pkg::REG_SWRST, '{exp_pkg::SWRST_KEY2, 8'h00, 8'h00}, 1);
      wait_ready();
      chk8(misc_config_reg, exp_pkg::MISC_RESET);
      rd(7'h20, 8'h05, '{8'h00, 8'h00, 8'h00}, 1);
      $display("test software reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
